// [sim/crs_alu_model.sv]
// Adder model of the ALU that feeds the register state block
`timescale 1ns/1ps
`default_nettype none
module crs_alu_model (
    input wire logic [7:0] op_a,
    input wire logic [7:0] op_b,
    output logic [7:0] sum,
    output logic [7:0] flags
);
    import crs_pkg::*;
    logic [8:0] full;
    always_comb begin
        full = {1'b0, op_a} + {1'b0, op_b};
        sum = full[7:0];
        flags = 8'h00;
        flags[FLAG_V] = (op_a[7] == op_b[7]) && (full[7] != op_a[7]);
        flags[FLAG_N] = full[7];
        flags[FLAG_Z] = (full[7:0] == 8'h00);
        flags[FLAG_C] = full[8];
    end
endmodule : crs_alu_model
`default_nettype wire

// [sim/crs_core_state_tb.sv]
// Self-checking bench for the CPU core register state block
`timescale 1ns/1ps
`default_nettype none
module crs_core_state_tb;
    import crs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] rd_a_addr = 5'h00, rd_b_addr = 5'h00, wr8_addr = 5'h00;
    logic [3:0] rd_w_pair = 4'h0, wr16_pair = 4'h0;
    logic wr8_en = 1'b0, wr16_en = 1'b0, irq_take = 1'b0, interrupt_return = 1'b0;
    logic io_en = 1'b0, io_we = 1'b0, ds_en = 1'b0, ds_we = 1'b0, got_hit;
    logic pgm_load = 1'b0, pgm_load_ext = 1'b0, io_hit, ds_hit, ptr_valid;
    logic [7:0] wr8_data = 8'h00, flag_we = 8'h00, io_wdata = 8'h00, ds_wdata = 8'h00;
    logic [7:0] flag_in, rd_a_data, rd_b_data, io_rdata, ds_rdata, cpu_flag_register;
    logic [7:0] alu_sum, got8;
    logic [15:0] wr16_data = 16'h0000, ds_addr = 16'h0000, rd_w_data, ptr_addr, sp;
    logic [5:0] ptr_disp = 6'h00, io_addr = 6'h00;
    logic [1:0] ptr_sel = 2'h0;
    logic [16:0] pgm_addr;
    crs_ptr_op_type ptr_op = PTR_NONE;
    crs_sp_op_type sp_op = SP_NONE;
    int bad_count = 0, total_checks = 0, cycles = 0;

    crs_core_state crs_core_state_i (.clk(clk), .rst_n(rst_n), .rd_a_addr(rd_a_addr),
        .rd_b_addr(rd_b_addr), .rd_w_pair(rd_w_pair), .rd_a_data(rd_a_data),
        .rd_b_data(rd_b_data), .rd_w_data(rd_w_data), .wr8_en(wr8_en), .wr8_addr(wr8_addr),
        .wr8_data(wr8_data), .wr16_en(wr16_en), .wr16_pair(wr16_pair), .wr16_data(wr16_data),
        .flag_we(flag_we), .flag_in(flag_in), .ptr_op(ptr_op), .ptr_sel(ptr_sel),
        .ptr_disp(ptr_disp), .ptr_addr(ptr_addr), .ptr_valid(ptr_valid), .sp_op(sp_op),
        .irq_take(irq_take), .interrupt_return(interrupt_return), .sp(sp), .io_en(io_en),
        .io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_hit(io_hit), .ds_en(ds_en), .ds_we(ds_we), .ds_addr(ds_addr),
        .ds_wdata(ds_wdata), .ds_rdata(ds_rdata), .ds_hit(ds_hit), .pgm_load(pgm_load),
        .pgm_load_ext(pgm_load_ext), .pgm_addr(pgm_addr),
        .cpu_flag_register(cpu_flag_register));
    crs_alu_model crs_alu_model_i (.op_a(rd_a_data), .op_b(rd_b_data), .sum(alu_sum),
        .flags(flag_in));

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    // ------------------------------------------------------------
    // Compare and access tasks
    // ------------------------------------------------------------
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk8

    task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk16

    task automatic chk1(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask : chk1

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic io_acc(input logic we, input logic [5:0] a, input logic [7:0] d);
        io_en = 1'b1;
        io_we = we;
        io_addr = a;
        io_wdata = d;
        tick();
        got8 = io_rdata;
        got_hit = io_hit;
        io_en = 1'b0;
        io_we = 1'b0;
        tick();
    endtask : io_acc

    task automatic ds_acc(input logic we, input logic [15:0] a, input logic [7:0] d);
        ds_en = 1'b1;
        ds_we = we;
        ds_addr = a;
        ds_wdata = d;
        tick();
        got8 = ds_rdata;
        got_hit = ds_hit;
        ds_en = 1'b0;
        ds_we = 1'b0;
        tick();
    endtask : ds_acc

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk8("flags", FLAGS_RESET, cpu_flag_register);
        chk16("sp", SP_RESET, sp);
        io_acc(1'b0, 6'h00, 8'h00);
        chk1("io_hit", 1'b0, got_hit);
        ds_acc(1'b0, DS_EXT_IO_BASE, 8'h00);
        chk1("ds_hit", 1'b0, got_hit);
    endtask : t_reset

    task automatic t_regs();
        wr8_en = 1'b1;
        wr8_addr = 5'h05;
        wr8_data = 8'hAA;
        rd_a_addr = 5'h05;
        wr16_en = 1'b1;
        wr16_pair = 4'hD;
        wr16_data = 16'h1234;
        rd_w_pair = 4'hD;
        tick();
        wr8_en = 1'b0;
        wr16_en = 1'b0;
        chk8("rd_a_data", 8'hAA, rd_a_data);
        chk16("rd_w_data", 16'h1234, rd_w_data);
        ds_acc(1'b0, 16'h001A, 8'h00);
        chk8("ds low", 8'h34, got8);
        chk1("ds_hit", 1'b1, got_hit);
        rd_a_addr = 5'h1F;
        ds_acc(1'b1, DS_REG_LAST, 8'h5A);
        chk8("r31", 8'h5A, rd_a_data);
    endtask : t_regs

    task automatic t_alu();
        logic [7:0] a [4] = '{8'h7F, 8'h80, 8'hF0, 8'hFF};
        logic [7:0] b [4] = '{8'h01, 8'h80, 8'h01, 8'h02};
        logic [7:0] s [4] = '{8'h80, 8'h00, 8'hF1, 8'h01};
        logic [7:0] f [4] = '{8'h0C, 8'h1B, 8'h14, 8'h01};
        for (int i = 0; i < 4; i++) begin
            wr16_en = 1'b1;
            wr16_pair = 4'h0;
            wr16_data = {b[i], a[i]};
            rd_a_addr = 5'h00;
            rd_b_addr = 5'h01;
            tick();
            wr16_en = 1'b0;
            wr8_en = 1'b1;
            wr8_addr = 5'h03;
            wr8_data = alu_sum;
            flag_we = 8'h1F;
            rd_a_addr = 5'h03;
            tick();
            wr8_en = 1'b0;
            flag_we = 8'h00;
            chk8("result", s[i], rd_a_data);
            chk8("flags", f[i], cpu_flag_register);
        end
    endtask : t_alu

    task automatic t_stack();
        crs_sp_op_type ops [4] = '{SP_PUSH1, SP_POP1, SP_PUSH2, SP_POP2};
        logic [15:0] ex [4] = '{16'h10FE, 16'h10FF, 16'h10FD, 16'h10FF};
        io_acc(1'b1, IO_SP_HI, 8'h10);
        chk16("sp", 16'h1000, sp);
        io_acc(1'b1, IO_SP_LO, 8'hFF);
        chk16("sp", 16'h10FF, sp);
        ds_acc(1'b0, 16'h005E, 8'h00);
        chk8("sp alias", 8'h10, got8);
        for (int i = 0; i < 4; i++) begin
            sp_op = ops[i];
            tick();
            chk16("sp", ex[i], sp);
        end
        sp_op = SP_NONE;
        io_acc(1'b1, IO_FLAGS, 8'h80);
        chk8("flags", 8'h80, cpu_flag_register);
        ds_acc(1'b0, 16'h005F, 8'h00);
        chk8("flags alias", 8'h80, got8);
        chk1("ds_hit", 1'b1, got_hit);
        irq_take = 1'b1;
        tick();
        irq_take = 1'b0;
        chk16("sp", 16'h10FD, sp);
        chk1("enable", 1'b0, cpu_flag_register[FLAG_I]);
        interrupt_return = 1'b1;
        tick();
        interrupt_return = 1'b0;
        chk16("sp", 16'h10FF, sp);
        chk1("enable", 1'b1, cpu_flag_register[FLAG_I]);
        ds_acc(1'b1, 16'h005D, 8'h80);
        chk16("sp", 16'h1080, sp);
    endtask : t_stack

    task automatic t_ptr();
        wr16_en = 1'b1;
        wr16_pair = 4'hF;
        wr16_data = 16'h0100;
        tick();
        wr16_en = 1'b0;
        ptr_sel = 2'h2;
        ptr_disp = 6'h05;
        ptr_op = PTR_DISP;
        tick();
        chk16("ptr_addr", 16'h0105, ptr_addr);
        chk1("ptr_valid", 1'b1, ptr_valid);
        ptr_op = PTR_POSTINC;
        tick();
        chk16("ptr_addr", 16'h0100, ptr_addr);
        ptr_op = PTR_PREDEC;
        tick();
        chk16("ptr_addr", 16'h0100, ptr_addr);
        ptr_op = PTR_NONE;
        rd_w_pair = 4'hF;
        tick();
        chk16("rd_w_data", 16'h0100, rd_w_data);
        chk1("ptr_valid", 1'b0, ptr_valid);
    endtask : t_ptr

    task automatic t_pgm();
        io_acc(1'b1, IO_PAGE_SEL, 8'hFF);
        io_acc(1'b0, IO_PAGE_SEL, 8'h00);
        chk8("page", 8'h01, got8);
        chk1("io_hit", 1'b1, got_hit);
        pgm_load = 1'b1;
        pgm_load_ext = 1'b1;
        tick();
        chk16("pgm low", 16'h0100, pgm_addr[15:0]);
        chk1("pgm high", 1'b1, pgm_addr[16]);
        pgm_load_ext = 1'b0;
        tick();
        chk1("pgm high", 1'b0, pgm_addr[16]);
        pgm_load = 1'b0;
    endtask : t_pgm

    // ------------------------------------------------------------
    // Run
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            results();
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_regs();
        t_alu();
        t_stack();
        t_ptr();
        t_pgm();
        results();
    end
endmodule : crs_core_state_tb
`default_nettype wire

// [verilog/crs_core_state.sv]
// Register file, flags, stack pointer and program page select of the CPU core
`timescale 1ns/1ps
`default_nettype none
module crs_core_state (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] rd_a_addr,
    input wire logic [4:0] rd_b_addr,
    input wire logic [3:0] rd_w_pair,
    output logic [7:0] rd_a_data,
    output logic [7:0] rd_b_data,
    output logic [15:0] rd_w_data,
    input wire logic wr8_en,
    input wire logic [4:0] wr8_addr,
    input wire logic [7:0] wr8_data,
    input wire logic wr16_en,
    input wire logic [3:0] wr16_pair,
    input wire logic [15:0] wr16_data,
    input wire logic [7:0] flag_we,
    input wire logic [7:0] flag_in,
    input wire crs_pkg::crs_ptr_op_type ptr_op,
    input wire logic [1:0] ptr_sel,
    input wire logic [5:0] ptr_disp,
    output logic [15:0] ptr_addr,
    output logic ptr_valid,
    input wire crs_pkg::crs_sp_op_type sp_op,
    input wire logic irq_take,
    input wire logic interrupt_return,
    output logic [15:0] sp,
    input wire logic io_en,
    input wire logic io_we,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_hit,
    input wire logic ds_en,
    input wire logic ds_we,
    input wire logic [15:0] ds_addr,
    input wire logic [7:0] ds_wdata,
    output logic [7:0] ds_rdata,
    output logic ds_hit,
    input wire logic pgm_load,
    input wire logic pgm_load_ext,
    output logic [16:0] pgm_addr,
    output logic [7:0] cpu_flag_register
);
    import crs_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] regs_r [NUM_REGS];
    logic [7:0] regs_nxt [NUM_REGS];
    logic [7:0] flags_r, flags_nxt;
    logic [15:0] sp_r, sp_nxt;
    logic [7:0] page_r, page_nxt;
    logic [7:0] rd_a_r, rd_a_nxt, rd_b_r, rd_b_nxt;
    logic [15:0] rd_w_r, rd_w_nxt;
    logic [15:0] ptr_addr_r, ptr_addr_nxt;
    logic ptr_valid_r, ptr_valid_nxt;
    logic [7:0] io_rdata_r, io_rdata_nxt, ds_rdata_r, ds_rdata_nxt;
    logic io_hit_r, io_hit_nxt, ds_hit_r, ds_hit_nxt;
    logic [16:0] pgm_addr_r, pgm_addr_nxt;

    // ----------------------------------------
    // Data space and pointer base decode, shared by both paths
    // ----------------------------------------
    logic ds_is_reg, ds_is_io, ds_io_we;
    logic [5:0] ds_io_addr;
    logic [4:0] ptr_lo;
    logic [15:0] ptr_base;

    always_comb begin
        ds_is_reg = ds_en && (ds_addr <= DS_REG_LAST);
        ds_is_io = ds_en && (ds_addr >= DS_IO_BASE) && (ds_addr < DS_EXT_IO_BASE);
        ds_io_addr = 6'(ds_addr - DS_IO_BASE);
        ds_io_we = ds_is_io && ds_we;
        ptr_lo = 5'(PTR_BASE_LO + {2'b00, ptr_sel, 1'b0});
        ptr_base = {regs_r[ptr_lo + 5'h01], regs_r[ptr_lo]};
    end

    // ----------------------------------------
    // Register file next state
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            regs_nxt[i] = regs_r[i];
        end
        if (ptr_op == PTR_POSTINC) begin
            {regs_nxt[ptr_lo + 5'h01], regs_nxt[ptr_lo]} = ptr_base + 16'h0001;
        end else if (ptr_op == PTR_PREDEC) begin
            {regs_nxt[ptr_lo + 5'h01], regs_nxt[ptr_lo]} = ptr_base - 16'h0001;
        end
        if (ds_is_reg && ds_we) begin
            regs_nxt[ds_addr[4:0]] = ds_wdata;
        end
        if (wr16_en) begin
            {regs_nxt[{wr16_pair, 1'b1}], regs_nxt[{wr16_pair, 1'b0}]} = wr16_data;
        end
        if (wr8_en) begin
            regs_nxt[wr8_addr] = wr8_data;
        end
        rd_a_nxt = regs_nxt[rd_a_addr];
        rd_b_nxt = regs_nxt[rd_b_addr];
        rd_w_nxt = {regs_nxt[{rd_w_pair, 1'b1}], regs_nxt[{rd_w_pair, 1'b0}]};
    end

    // ----------------------------------------
    // Pointer effective address
    // ----------------------------------------
    always_comb begin
        ptr_valid_nxt = (ptr_op != PTR_NONE);
        ptr_addr_nxt = ptr_addr_r;
        case (ptr_op)
            PTR_DISP: begin
                ptr_addr_nxt = ptr_base + {10'h000, ptr_disp};
            end
            PTR_POSTINC: begin
                ptr_addr_nxt = ptr_base;
            end
            PTR_PREDEC: begin
                ptr_addr_nxt = ptr_base - 16'h0001;
            end
            default: begin
                ptr_addr_nxt = ptr_addr_r;
            end
        endcase
    end

    // ----------------------------------------
    // Flags, stack pointer, page select
    // ----------------------------------------
    always_comb begin
        // flag values come from the ALU
        flags_nxt = (flags_r & ~flag_we) | (flag_in & flag_we);
        if ((io_en && io_we && io_addr == IO_FLAGS) || (ds_io_we && ds_io_addr == IO_FLAGS)) begin
            flags_nxt = io_en && io_we && io_addr == IO_FLAGS ? io_wdata : ds_wdata;
        end
        // enable bit on entry and return
        if (irq_take) begin
            flags_nxt[FLAG_I] = 1'b0;
        end else if (interrupt_return) begin
            flags_nxt[FLAG_I] = 1'b1;
        end
        flags_nxt[FLAG_S] = flags_nxt[FLAG_N] ^ flags_nxt[FLAG_V];

        sp_nxt = sp_r;
        if (irq_take) begin
            sp_nxt = sp_r - 16'h0002;
        end else if (interrupt_return) begin
            sp_nxt = sp_r + 16'h0002;
        end else begin
            case (sp_op)
                SP_PUSH1: sp_nxt = sp_r - 16'h0001;
                SP_POP1: sp_nxt = sp_r + 16'h0001;
                SP_PUSH2: sp_nxt = sp_r - 16'h0002;
                SP_POP2: sp_nxt = sp_r + 16'h0002;
                default: sp_nxt = sp_r;
            endcase
        end
        if (io_en && io_we && io_addr == IO_SP_LO) begin
            sp_nxt[7:0] = io_wdata;
        end else if (ds_io_we && ds_io_addr == IO_SP_LO) begin
            sp_nxt[7:0] = ds_wdata;
        end
        if (io_en && io_we && io_addr == IO_SP_HI) begin
            sp_nxt[15:8] = io_wdata;
        end else if (ds_io_we && ds_io_addr == IO_SP_HI) begin
            sp_nxt[15:8] = ds_wdata;
        end

        // Only the page bit is implemented
        page_nxt = page_r;
        if (io_en && io_we && io_addr == IO_PAGE_SEL) begin
            page_nxt = {7'h00, io_wdata[PAGE_BIT]};
        end else if (ds_io_we && ds_io_addr == IO_PAGE_SEL) begin
            page_nxt = {7'h00, ds_wdata[PAGE_BIT]};
        end

        pgm_addr_nxt = pgm_addr_r;
        if (pgm_load) begin
            pgm_addr_nxt = {pgm_load_ext ? page_r[PAGE_BIT] : 1'b0, regs_r[5'h1F], regs_r[5'h1E]};
        end
    end

    // ----------------------------------------
    // Read-back of I/O and data space
    // ----------------------------------------
    function automatic logic [8:0] io_read(input logic [5:0] a);
        // Bit 8 flags a mapped location
        if (a == IO_FLAGS) begin
            io_read = {1'b1, flags_r};
        end else if (a == IO_SP_HI) begin
            io_read = {1'b1, sp_r[15:8]};
        end else if (a == IO_SP_LO) begin
            io_read = {1'b1, sp_r[7:0]};
        end else if (a == IO_PAGE_SEL) begin
            io_read = {1'b1, page_r};
        end else begin
            io_read = 9'h000;
        end
    endfunction : io_read

    always_comb begin
        {io_hit_nxt, io_rdata_nxt} = io_en ? io_read(io_addr) : 9'h000;
        if (ds_is_reg) begin
            {ds_hit_nxt, ds_rdata_nxt} = {1'b1, regs_r[ds_addr[4:0]]};
        end else if (ds_is_io) begin
            {ds_hit_nxt, ds_rdata_nxt} = io_read(ds_io_addr);
        end else begin
            {ds_hit_nxt, ds_rdata_nxt} = 9'h000;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // every flop on the undivided core clock
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                regs_r[g] <= REG_RESET;
            end else begin
                regs_r[g] <= regs_nxt[g];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= FLAGS_RESET;
            sp_r <= SP_RESET;
            page_r <= PAGE_RESET;
            rd_a_r <= 8'h00;
            rd_b_r <= 8'h00;
            rd_w_r <= 16'h0000;
            ptr_addr_r <= 16'h0000;
            ptr_valid_r <= 1'b0;
            io_rdata_r <= 8'h00;
            io_hit_r <= 1'b0;
            ds_rdata_r <= 8'h00;
            ds_hit_r <= 1'b0;
            pgm_addr_r <= 17'h00000;
        end else begin
            flags_r <= flags_nxt;
            sp_r <= sp_nxt;
            page_r <= page_nxt;
            // operands latched for the next execute
            rd_a_r <= rd_a_nxt;
            rd_b_r <= rd_b_nxt;
            rd_w_r <= rd_w_nxt;
            ptr_addr_r <= ptr_addr_nxt;
            ptr_valid_r <= ptr_valid_nxt;
            io_rdata_r <= io_rdata_nxt;
            io_hit_r <= io_hit_nxt;
            ds_rdata_r <= ds_rdata_nxt;
            ds_hit_r <= ds_hit_nxt;
            pgm_addr_r <= pgm_addr_nxt;
        end
    end

    assign rd_a_data = rd_a_r;
    assign rd_b_data = rd_b_r;
    assign rd_w_data = rd_w_r;
    assign ptr_addr = ptr_addr_r;
    assign ptr_valid = ptr_valid_r;
    assign sp = sp_r;
    assign io_rdata = io_rdata_r;
    assign io_hit = io_hit_r;
    assign ds_rdata = ds_rdata_r;
    assign ds_hit = ds_hit_r;
    assign pgm_addr = pgm_addr_r;
    assign cpu_flag_register = flags_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic sp_bus_wr;
    assign sp_bus_wr = (io_en && io_we && (io_addr == IO_SP_LO || io_addr == IO_SP_HI))
        || (ds_io_we && (ds_io_addr == IO_SP_LO || ds_io_addr == IO_SP_HI));

    AST_SIGN: assert property (flags_r[FLAG_S] == (flags_r[FLAG_N] ^ flags_r[FLAG_V]))
        else $error("sign flag differs from N xor V");
    AST_PUSH1: assert property ((sp_op == SP_PUSH1 && !irq_take && !interrupt_return
        && !sp_bus_wr) |=> sp_r == $past(sp_r) - 16'h0001)
        else $error("byte push did not decrement by one");
    AST_RET2: assert property ((interrupt_return && !irq_take && !sp_bus_wr)
        |=> sp_r == $past(sp_r) + 16'h0002 && flags_r[FLAG_I])
        else $error("interrupt return wrong stack or enable");
    AST_IRQ: assert property (irq_take |=> !flags_r[FLAG_I])
        else $error("enable bit not cleared on interrupt");
    AST_FWD: assert property ((wr8_en && rd_a_addr == wr8_addr) |=> rd_a_data == $past(wr8_data))
        else $error("operand missed same-cycle write-back");
    AST_SPLO: assert property ((io_en && io_we && io_addr == IO_SP_LO && sp_op == SP_NONE
        && !irq_take && !interrupt_return && !ds_io_we) |=> sp_r[15:8] == $past(sp_r[15:8]))
        else $error("low byte write disturbed high byte");
    AST_PAGE: assert property (pgm_load |=>
        pgm_addr[16] == ($past(pgm_load_ext) & $past(page_r[PAGE_BIT])))
        else $error("program page bit misapplied");
    AST_EXT: assert property ((ds_en && ds_addr >= DS_EXT_IO_BASE) |=> !ds_hit)
        else $error("extended area decoded locally");
    AST_ALIAS: assert property ((ds_en && ds_addr == (DS_IO_BASE + 16'h003F))
        |=> ds_hit && ds_rdata == $past(flags_r))
        else $error("flag register alias wrong");
    AST_PINC: assert property ((ptr_op == PTR_POSTINC && !wr8_en && !wr16_en && !ds_we)
        |=> ptr_addr + 16'h0001 == {regs_r[$past(ptr_lo) + 5'h01], regs_r[$past(ptr_lo)]})
        else $error("post-increment pointer wrong");
endmodule : crs_core_state
`default_nettype wire

// [verilog/crs_pkg.sv]
// Constants and types shared by the CPU core register state block
package crs_pkg;
    localparam int NUM_REGS = 32;
    localparam int CLK_PERIOD_NS = 100;
    localparam logic [5:0] IO_PAGE_SEL = 6'h3B;
    localparam logic [5:0] IO_SP_LO = 6'h3D;
    localparam logic [5:0] IO_SP_HI = 6'h3E;
    localparam logic [5:0] IO_FLAGS = 6'h3F;
    localparam logic [15:0] DS_REG_LAST = 16'h001F;
    localparam logic [15:0] DS_IO_BASE = 16'h0020;
    localparam logic [15:0] DS_EXT_IO_BASE = 16'h0060;
    localparam logic [4:0] PTR_BASE_LO = 5'h1A;
    localparam int FLAG_I = 7;
    localparam int FLAG_S = 4;
    localparam int FLAG_V = 3;
    localparam int FLAG_N = 2;
    localparam int FLAG_Z = 1;
    localparam int FLAG_C = 0;
    localparam int PAGE_BIT = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;

    typedef enum logic [2:0] {
        SP_NONE,
        SP_PUSH1,
        SP_POP1,
        SP_PUSH2,
        SP_POP2
    } crs_sp_op_type;

    typedef enum logic [1:0] {
        PTR_NONE,
        PTR_DISP,
        PTR_POSTINC,
        PTR_PREDEC
    } crs_ptr_op_type;
endpackage : crs_pkg
